// ==== mic_irq_ctrl.sv ====
// Interrupt controller: enables, masking, level and natural priority
// arbitration, vectoring and service level tracking for the core.
// Assumes the core reports instruction boundaries and return opcodes, and
// that peripherals hold their request flags until cleared.
`timescale 1ns/1ps
`include "mic_defs.svh"

module mic_irq_ctrl
  import mic_pkg::*;
#(
  parameter int NLINES = `MIC_NUM_LINES
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  // Special function register bus
  input  wire mic_pkg::mic_sfr_s sfr,
  output logic [7:0]           sfr_rdata,
  output logic                 sfr_hit,
  // Peripheral request flags
  input  wire mic_pkg::mic_src_s src,
  // External interrupt pins, active low
  input  wire logic            ext0_pin_n,
  input  wire logic            ext1_pin_n,
  output logic                 ext0_req,
  output logic                 ext1_req,
  // Core sequencing
  input  wire mic_pkg::mic_core_s core,
  output logic                 irq_take,
  output logic [15:0]          irq_vector,
  output logic [3:0]           irq_line,
  output logic                 clr_ext0,
  output logic                 clr_tmr0,
  output logic                 clr_ext1,
  output logic                 clr_tmr1,
  output logic [1:0]           active_level
);

  // ----------------------------------------------------------------------
  // Vector lookup
  // ----------------------------------------------------------------------
  // Vector address of a line, indexed by natural priority.
  function automatic logic [15:0] line_vector(input logic [3:0] n);
    case (n)
      4'h0:    line_vector = `MIC_VEC_FLASHDBG;
      4'h1:    line_vector = `MIC_VEC_EXT0;
      4'h2:    line_vector = `MIC_VEC_TMR0;
      4'h3:    line_vector = `MIC_VEC_EXT1;
      4'h4:    line_vector = `MIC_VEC_TMR1;
      4'h5:    line_vector = `MIC_VEC_UART0;
      4'h6:    line_vector = `MIC_VEC_UART1;
      4'h7:    line_vector = `MIC_VEC_RADIO;
      4'h8:    line_vector = `MIC_VEC_TMR2;
      4'h9:    line_vector = `MIC_VEC_CONV;
      4'hA:    line_vector = `MIC_VEC_TMR3;
      4'hB:    line_vector = `MIC_VEC_ALARM;
      default: line_vector = 16'h0000;
    endcase
  endfunction : line_vector

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  en_main_r;
  logic [4:0]  en_ext_r;
  logic [10:0] prio_r;       // Level bits for lines 1 to 11.
  logic        hold_r;       // One more instruction before vectoring.
  logic        act_low_r;
  logic        act_high_r;
  logic        act_top_r;
  logic        take_r;
  logic [15:0] vec_r;
  logic [3:0]  line_r;
  logic [3:0]  clr_r;

  // ----------------------------------------------------------------------
  // External pins
  // ----------------------------------------------------------------------
  // Pins arrive asynchronously, so each passes a filtering synchroniser.
  logic ext0_lvl;
  logic ext1_lvl;

  mic_pin_sync u_sync0 (
    .mclk  (mclk),
    .rst   (rst),
    .pin   (ext0_pin_n),
    .level (ext0_lvl)
  );

  mic_pin_sync u_sync1 (
    .mclk  (mclk),
    .rst   (rst),
    .pin   (ext1_pin_n),
    .level (ext1_lvl)
  );

  // Low level request to the timer/control block that holds the flags.
  assign ext0_req = ~ext0_lvl;
  assign ext1_req = ~ext1_lvl;

  // ----------------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------------
  wire hit_en_main = (sfr.addr == `MIC_ADDR_EN_MAIN);
  wire hit_en_ext  = (sfr.addr == `MIC_ADDR_EN_EXT);
  wire hit_pr_main = (sfr.addr == `MIC_ADDR_PRIO_MAIN);
  wire hit_pr_ext  = (sfr.addr == `MIC_ADDR_PRIO_EXT);
  wire wr_any      = sfr.wr & (hit_en_main | hit_en_ext |
                               hit_pr_main | hit_pr_ext);

  assign sfr_hit = hit_en_main | hit_en_ext;

  // Priority registers live elsewhere; only their writes matter here.
  assign sfr_rdata = hit_en_main ? en_main_r :
                     hit_en_ext  ? (`MIC_EN_EXT_ONES |
                                    {3'h0, en_ext_r}) :
                     8'h00;

  // ----------------------------------------------------------------------
  // Line requests
  // ----------------------------------------------------------------------
  wire gate = en_main_r[`MIC_EN_GATE_BIT];
  wire conv_req = src.conv_cipher_irq_flag |
                  (src.conv_local_irq_en & src.conv_local_irq_flag) |
                  (src.cipher_local_irq_en & src.cipher_local_irq_flag);

  // Flags set by software arrive on the same inputs, so they request alike.
  logic [NLINES-1:0] pend;
  assign pend[0]  = src.flashdbg_irq_flag & src.flashdbg_irq_en;
  assign pend[1]  = gate & en_main_r[`MIC_EN_EXT0_BIT] &
                    src.ext0_irq_flag;
  assign pend[2]  = gate & en_main_r[`MIC_EN_TMR0_BIT] &
                    src.tmr0_overflow_flag;
  assign pend[3]  = gate & en_main_r[`MIC_EN_EXT1_BIT] &
                    src.ext1_irq_flag;
  assign pend[4]  = gate & en_main_r[`MIC_EN_TMR1_BIT] &
                    src.tmr1_overflow_flag;
  assign pend[5]  = gate & en_main_r[`MIC_EN_UART0_BIT] &
                    (src.uart0_tx_flag | src.uart0_rx_flag);
  assign pend[6]  = gate & en_main_r[`MIC_EN_UART1_BIT] &
                    (src.uart1_tx_flag | src.uart1_rx_flag);
  assign pend[7]  = gate & en_ext_r[`MIC_EX_RADIO_BIT] &
                    src.radio_irq_flag;
  assign pend[8]  = gate & en_ext_r[`MIC_EX_TMR2_BIT] &
                    src.tmr2_overflow_flag;
  assign pend[9]  = gate & en_ext_r[`MIC_EX_CONV_BIT] & conv_req;
  assign pend[10] = gate & en_ext_r[`MIC_EX_TMR3_BIT] &
                    src.tmr3_overflow_flag;
  assign pend[11] = gate & en_ext_r[`MIC_EX_ALARM_BIT] &
                    src.clock_alarm_irq_flag;

  // ----------------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------------
  // Lowest set index wins within a level group.
  function automatic logic [3:0] first_set(input logic [NLINES-1:0] v);
    first_set = 4'hF;
    for (int i = NLINES - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction : first_set

  wire [NLINES-1:0] hi_mask = {prio_r, 1'b0};
  wire [NLINES-1:0] pend_hi = pend & hi_mask;
  wire [NLINES-1:0] pend_lo = pend & ~hi_mask & {{(NLINES-1){1'b1}}, 1'b0};

  // Level first, then natural priority.
  wire [3:0] win_line = pend[0]    ? 4'h0 :
                        (|pend_hi) ? first_set(pend_hi) :
                        first_set(pend_lo);

  // A request may preempt only when its level beats the active one.
  wire may_top  = pend[0] & ~act_top_r;
  wire may_high = (|pend_hi) & ~act_high_r & ~act_top_r;
  wire may_low  = (|pend_lo) & ~act_low_r & ~act_high_r &
                  ~act_top_r;
  wire may_take = may_top | may_high | may_low;

  // Take only at a boundary that ends neither a return nor a register
  // write that the hold covers; such a boundary lets one more run.
  wire take = core.boundary & ~hold_r & ~core.is_return & ~wr_any &
              may_take & ~take_r;

  // ----------------------------------------------------------------------
  // Enable and priority registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_main_r <= `MIC_EN_MAIN_RST;
      en_ext_r  <= `MIC_EN_EXT_RST;
      prio_r    <= `MIC_PRIO_RST;
    end else begin
      if (sfr.wr & hit_en_main) begin
        en_main_r <= sfr.wdata;
      end
      if (sfr.wr & hit_en_ext) begin
        en_ext_r <= sfr.wdata[4:0];
      end
      if (sfr.wr & hit_pr_main) begin
        prio_r[5:0] <= {sfr.wdata[6], sfr.wdata[4:0]};
      end
      if (sfr.wr & hit_pr_ext) begin
        prio_r[10:6] <= sfr.wdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Instruction hold
  // ----------------------------------------------------------------------
  // Armed by an enable/priority write in mid-instruction and dropped at
  // the boundary that ends it, so that boundary is refused and the next
  // is free. A return or a write in the boundary cycle is refused by the
  // take term itself, so the boundary clear wins here on purpose.
  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else if (core.boundary) begin
      hold_r <= 1'b0;
    end else if (wr_any) begin
      hold_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Active service levels
  // ----------------------------------------------------------------------
  // A return ends the highest active level, exposing the one below.
  wire ret = core.boundary & core.is_return;

  always_ff @(posedge mclk) begin
    if (rst) begin
      act_low_r  <= 1'b0;
      act_high_r <= 1'b0;
      act_top_r  <= 1'b0;
    end else if (take) begin
      act_top_r  <= act_top_r | may_top;
      act_high_r <= act_high_r | (~may_top & may_high);
      act_low_r  <= act_low_r | (~may_top & ~may_high);
    end else if (ret) begin
      if (act_top_r) begin
        act_top_r <= 1'b0;
      end else if (act_high_r) begin
        act_high_r <= 1'b0;
      end else begin
        act_low_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Vector output and hardware flag clears
  // ----------------------------------------------------------------------
  // Registered one-cycle take pulse with the chosen vector held after it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      take_r <= 1'b0;
      vec_r  <= 16'h0000;
      line_r <= 4'h0;
      clr_r  <= 4'h0;
    end else begin
      take_r <= take;
      clr_r  <= 4'h0;
      if (take) begin
        vec_r  <= line_vector(win_line);
        line_r <= win_line;
        clr_r  <= {win_line == 4'h4, win_line == 4'h3,
                   win_line == 4'h2, win_line == 4'h1};
      end
    end
  end

  assign irq_take     = take_r;
  assign irq_vector   = vec_r;
  assign irq_line     = line_r;
  assign clr_ext0     = clr_r[0];
  assign clr_tmr0     = clr_r[1];
  assign clr_ext1     = clr_r[2];
  assign clr_tmr1     = clr_r[3];
  // Software must clear the level-held flags itself before returning.
  assign active_level = act_top_r  ? 2'h3 :
                        act_high_r ? 2'h2 :
                        act_low_r  ? 2'h1 : 2'h0;

endmodule : mic_irq_ctrl

// ==== mic_defs.svh ====
// Constants of the interrupt controller: register addresses, bit positions,
// reset values and vector addresses.
// Assumes nothing; included by the package and the design modules.
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH

// ----------------------------------------------------------------------
// Register addresses on the special function register bus
// ----------------------------------------------------------------------
`define MIC_ADDR_EN_MAIN   8'hA8
`define MIC_ADDR_EN_EXT    8'hE8
`define MIC_ADDR_PRIO_MAIN 8'hB8
`define MIC_ADDR_PRIO_EXT  8'hF8

// ----------------------------------------------------------------------
// Main enable register bit positions
// ----------------------------------------------------------------------
`define MIC_EN_GATE_BIT    7
`define MIC_EN_UART1_BIT   6
`define MIC_EN_UART0_BIT   4
`define MIC_EN_TMR1_BIT    3
`define MIC_EN_EXT1_BIT    2
`define MIC_EN_TMR0_BIT    1
`define MIC_EN_EXT0_BIT    0

// ----------------------------------------------------------------------
// Extended enable register bit positions
// ----------------------------------------------------------------------
`define MIC_EX_ALARM_BIT   4
`define MIC_EX_TMR3_BIT    3
`define MIC_EX_CONV_BIT    2
`define MIC_EX_TMR2_BIT    1
`define MIC_EX_RADIO_BIT   0

// ----------------------------------------------------------------------
// Reset values and read-as-one masks
// ----------------------------------------------------------------------
`define MIC_EN_MAIN_RST    8'h00
`define MIC_EN_EXT_RST     5'h00
`define MIC_EN_EXT_ONES    8'hE0
`define MIC_PRIO_RST       11'h000

// ----------------------------------------------------------------------
// Vector addresses, indexed by natural priority 0 to 11
// ----------------------------------------------------------------------
`define MIC_VEC_FLASHDBG   16'h0033
`define MIC_VEC_EXT0       16'h0003
`define MIC_VEC_TMR0       16'h000B
`define MIC_VEC_EXT1       16'h0013
`define MIC_VEC_TMR1       16'h001B
`define MIC_VEC_UART0      16'h0023
`define MIC_VEC_UART1      16'h003B
`define MIC_VEC_RADIO      16'h0043
`define MIC_VEC_TMR2       16'h004B
`define MIC_VEC_CONV       16'h0053
`define MIC_VEC_TMR3       16'h005B
`define MIC_VEC_ALARM      16'h0063

`define MIC_NUM_LINES      12

`endif

// ==== mic_pkg.sv ====
// Types shared by the interrupt controller modules.
// Assumes mic_defs.svh is on the include path.
`include "mic_defs.svh"

package mic_pkg;

  // Service level: none, low, high, highest (flash/debug only).
  typedef enum logic [3:0] {
    MIC_LVL_NONE = 4'b0001,
    MIC_LVL_LOW  = 4'b0010,
    MIC_LVL_HIGH = 4'b0100,
    MIC_LVL_TOP  = 4'b1000
  } mic_level_e;

  // Raw request flags from the peripherals.
  typedef struct packed {
    logic flashdbg_irq_flag;
    logic ext0_irq_flag;
    logic tmr0_overflow_flag;
    logic ext1_irq_flag;
    logic tmr1_overflow_flag;
    logic uart0_tx_flag;
    logic uart0_rx_flag;
    logic uart1_tx_flag;
    logic uart1_rx_flag;
    logic radio_irq_flag;
    logic tmr2_overflow_flag;
    logic conv_cipher_irq_flag;
    logic conv_local_irq_en;
    logic conv_local_irq_flag;
    logic cipher_local_irq_en;
    logic cipher_local_irq_flag;
    logic tmr3_overflow_flag;
    logic clock_alarm_irq_flag;
    logic flashdbg_irq_en;
  } mic_src_s;

  // Special function register bus access from the core.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mic_sfr_s;

  // Core instruction boundary status.
  typedef struct packed {
    logic boundary;   // Instruction completes this cycle.
    logic is_return;  // That instruction is the interrupt return.
  } mic_core_s;

endpackage : mic_pkg

// ==== mic_pin_sync.sv ====
// Three-stage synchroniser for an asynchronous port pin.
// Assumes a single clock; a change counts once stages two and three agree.
`timescale 1ns/1ps
`include "mic_defs.svh"

module mic_pin_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // Stage one feeds stage two only; the filter looks at two and three.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      level_r <= 1'b1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign level = level_r;

endmodule : mic_pin_sync

// ==== mic_irq_ctrl_checker.sv ====
// Port checker for the interrupt controller, bound to its top module.
// Assumes one clock, mclk, and a synchronous active-high rst.
`timescale 1ns/1ps
`include "mic_defs.svh"

module mic_irq_ctrl_checker
  import mic_pkg::*;
#(
  parameter int NLINES = 12
) (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst,
  // Register bus
  input wire mic_pkg::mic_sfr_s  sfr,
  input wire logic [7:0]         sfr_rdata,
  input wire logic               sfr_hit,
  // Pin
  input wire logic               ext0_pin_n,
  input wire logic               ext0_req,
  // Core sequencing
  input wire mic_pkg::mic_core_s core,
  input wire logic               irq_take,
  input wire logic [15:0]        irq_vector,
  input wire logic [3:0]         irq_line,
  input wire logic               clr_ext0,
  input wire logic               clr_tmr0,
  input wire logic               clr_ext1,
  input wire logic               clr_tmr1,
  input wire logic [1:0]         active_level
);
  localparam logic [15:0] VT [12] = '{16'h0033, 16'h0003, 16'h000B,
    16'h0013, 16'h001B, 16'h0023, 16'h003B, 16'h0043, 16'h004B,
    16'h0053, 16'h005B, 16'h0063};
  logic        gate_r;
  logic        hold_r;
  logic        upd_w;
  logic [15:0] vec_w;
  logic [3:0]  clr_w;
  logic [3:0]  clr_x;

  // Writes to the two enable and two priority registers (1x1x_1000).
  assign upd_w = sfr.wr && sfr.addr[7] && sfr.addr[5] && sfr.addr[3:0] == 4'h8;
  assign vec_w = (irq_line < 4'hC) ? VT[irq_line] : 16'hFFFF;
  assign clr_w = {clr_ext0, clr_tmr0, clr_ext1, clr_tmr1};
  assign clr_x = {4{irq_take}} & {irq_line == 4'h1, irq_line == 4'h2,
                                  irq_line == 4'h3, irq_line == 4'h4};

  // Shadow gate bit and hold; the hold is kept here, not inferred.
  always_ff @(posedge mclk) begin
    if (rst) begin
      gate_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      if (sfr.wr && sfr.addr == 8'hA8) gate_r <= sfr.wdata[7];
      if (upd_w || core.boundary) hold_r <= upd_w && !core.boundary;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_ret;
    core.boundary && core.is_return;
  endsequence
  sequence s_pin_low;
    !ext0_pin_n [*6];
  endsequence

  property p_take_bnd;
    irq_take |-> $past(core.boundary) && !$past(hold_r) &&
                 !$past(upd_w) && !$past(core.is_return);
  endproperty
  property p_take_pulse;
    irq_take |=> !irq_take;
  endproperty
  property p_gate;
    irq_take && irq_line != 4'h0 |-> $past(gate_r);
  endproperty
  property p_fd;
    irq_take && irq_line == 4'h0 |-> irq_vector == 16'h0033 &&
                                     active_level == 2'h3;
  endproperty
  property p_vec;
    irq_take |-> irq_vector == vec_w;
  endproperty
  property p_clr;
    clr_w == clr_x;
  endproperty
  property p_pre;
    irq_take |-> active_level > $past(active_level);
  endproperty
  property p_ret;
    s_ret ##0 (active_level != 2'h0) |=>
      irq_take || active_level < $past(active_level);
  endproperty
  property p_e8;
    sfr.addr == 8'hE8 |-> sfr_rdata[7:5] == 3'h7;
  endproperty
  property p_map;
    sfr_hit == (sfr.addr == 8'hA8 || sfr.addr == 8'hE8) &&
      (sfr_hit || sfr_rdata == 8'h00);
  endproperty
  property p_pin;
    s_pin_low |-> ext0_req;
  endproperty

  a_take_bnd: assert property (p_take_bnd)
    else $error("take off boundary");
  a_take_pulse: assert property (p_take_pulse)
    else $error("take too long");
  a_gate: assert property (p_gate)
    else $error("take with gate clear");
  a_fd: assert property (p_fd)
    else $error("flash line wrong");
  a_vec: assert property (p_vec)
    else $error("wrong vector");
  a_clr: assert property (p_clr)
    else $error("wrong flag clear");
  a_pre: assert property (p_pre)
    else $error("equal level preempt");
  a_ret: assert property (p_ret)
    else $error("return kept level");
  a_e8: assert property (p_e8)
    else $error("upper bits not one");
  a_map: assert property (p_map)
    else $error("address map wrong");
  a_pin: assert property (p_pin)
    else $error("pin not seen");
endmodule : mic_irq_ctrl_checker

bind mic_irq_ctrl mic_irq_ctrl_checker #(.NLINES(NLINES)) u_chk (
  .mclk(mclk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit), .ext0_pin_n(ext0_pin_n), .ext0_req(ext0_req),
  .core(core), .irq_take(irq_take), .irq_vector(irq_vector),
  .irq_line(irq_line), .clr_ext0(clr_ext0), .clr_tmr0(clr_tmr0),
  .clr_ext1(clr_ext1), .clr_tmr1(clr_tmr1), .active_level(active_level)
);

// ==== mic_far_model.sv ====
// Far side of the controller: a core that reports instruction ends and
// the peripherals that own the request flags.
// Assumes bench commands arrive as one-cycle pulses on mclk.
`timescale 1ns/1ps
`include "mic_defs.svh"

module mic_far_model
  import mic_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Bench commands
  input  wire logic              step,
  input  wire logic              ret,
  input  wire mic_pkg::mic_src_s set_v,
  input  wire mic_pkg::mic_src_s clr_v,
  // Controller outputs
  input  wire logic              ext0_req,
  input  wire logic              clr_ext0,
  input  wire logic              clr_tmr0,
  input  wire logic              clr_ext1,
  input  wire logic              clr_tmr1,
  // Controller inputs
  output mic_pkg::mic_core_s     core,
  output mic_pkg::mic_src_s      src
);
  mic_src_s hw_set;
  mic_src_s hw_clr;

  // Hardware set and clear of the flags this side holds.
  always_comb begin
    hw_set = '0;
    hw_clr = '0;
    hw_set.ext0_irq_flag = ext0_req;
    hw_clr.ext0_irq_flag = clr_ext0;
    hw_clr.tmr0_overflow_flag = clr_tmr0;
    hw_clr.ext1_irq_flag = clr_ext1;
    hw_clr.tmr1_overflow_flag = clr_tmr1;
  end

  // A clear wins over a set in the same cycle, as a flag owner would.
  always_ff @(posedge mclk) begin
    if (rst) begin
      core <= '0;
      src  <= '0;
    end else begin
      core <= '{boundary: step, is_return: ret};
      src  <= (src | set_v | hw_set) & ~(clr_v | hw_clr);
    end
  end
endmodule : mic_far_model

// ==== tb_mic_irq_ctrl.sv ====
// Bench for the interrupt controller: map, masking, arbitration, holds
// and nesting, checked against a small reference model.
// Assumes the package, the controller and the far-side model come first.
`timescale 1ns/1ps
`include "mic_defs.svh"

module tb_mic_irq_ctrl;
  import mic_pkg::*;
  localparam logic [15:0] VEC [12] = '{16'h0033, 16'h0003, 16'h000B,
    16'h0013, 16'h001B, 16'h0023, 16'h003B, 16'h0043, 16'h004B,
    16'h0053, 16'h005B, 16'h0063};
  localparam logic [18:0] SRC [12] = '{19'h40001, 19'h20000, 19'h10000,
    19'h08000, 19'h04000, 19'h02000, 19'h00400, 19'h00200, 19'h00100,
    19'h00060, 19'h00004, 19'h00002};
  localparam int EB [12] = '{0, 0, 1, 2, 3, 4, 6, 8, 9, 10, 11, 12};
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        step = 1'b0;
  logic        ret = 1'b0;
  logic        ext0_pin_n = 1'b1;
  logic        ext1_pin_n = 1'b1;
  mic_sfr_s    sfr = '0;
  mic_src_s    set_v = '0;
  mic_src_s    clr_v = '0;
  mic_src_s    src;
  mic_core_s   core;
  logic [7:0]  sfr_rdata;
  logic [15:0] irq_vector;
  logic [3:0]  irq_line;
  logic [1:0]  active_level;
  logic        sfr_hit, ext0_req, ext1_req, irq_take;
  logic        clr_ext0, clr_tmr0, clr_ext1, clr_tmr1;
  logic [31:0] seed = 32'h0000000C;
  int          mismatches = 0;
  int          num_checks = 0;
  int          en16 = 0;
  int          prio = 0;
  int          pend = 0;
  int          hold = 0;
  int          last = 0;
  int          stack [$];

  // Core clock at 100 MHz.
  always #5 mclk = ~mclk;

  mic_irq_ctrl dut (
    .mclk(mclk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .src(src), .ext0_pin_n(ext0_pin_n),
    .ext1_pin_n(ext1_pin_n), .ext0_req(ext0_req), .ext1_req(ext1_req),
    .core(core), .irq_take(irq_take), .irq_vector(irq_vector),
    .irq_line(irq_line), .clr_ext0(clr_ext0), .clr_tmr0(clr_tmr0),
    .clr_ext1(clr_ext1), .clr_tmr1(clr_tmr1), .active_level(active_level)
  );
  mic_far_model far (
    .mclk(mclk), .rst(rst), .step(step), .ret(ret), .set_v(set_v),
    .clr_v(clr_v), .ext0_req(ext0_req), .clr_ext0(clr_ext0),
    .clr_tmr0(clr_tmr0), .clr_ext1(clr_ext1), .clr_tmr1(clr_tmr1),
    .core(core), .src(src)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Reference model: level first, then lowest natural number wins.
  function automatic int lvl(int l);
    if (l == 0) return 3;
    return prio[EB[l]] ? 2 : 1;
  endfunction : lvl
  function automatic int top();
    return stack.size() ? stack[$] : 0;
  endfunction : top
  function automatic int pick();
    int b;
    b = -1;
    for (int l = 0; l < 12; l++)
      if (pend[l] && (l == 0 || (en16[7] && en16[EB[l]])) &&
          lvl(l) > top() && (b < 0 || lvl(l) > lvl(b))) b = l;
    return b;
  endfunction : pick

  task automatic chk(string n, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // Register write; any enable or priority write holds one instruction.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    sfr.wr <= 1'b0;
    if (a == 8'hA8) en16[7:0] = d;
    if (a == 8'hE8) en16[12:8] = d[4:0];
    if (a == 8'hB8) prio[7:0] = d;
    if (a == 8'hF8) prio[12:8] = d[4:0];
    if (a[7] && a[5] && a[3:0] == 4'h8) hold = 1;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge mclk);
    sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    #1;
    chk("sfr_rdata", exp, sfr_rdata);
    chk("sfr_hit", a == 8'hA8 || a == 8'hE8, sfr_hit);
  endtask : rd
  task automatic flag(int l, bit on);
    @(posedge mclk);
    if (on) set_v <= SRC[l];
    else clr_v <= SRC[l];
    @(posedge mclk);
    set_v <= '0;
    clr_v <= '0;
    pend[l] = on;
  endtask : flag

  // One instruction end, optionally a return, compared with the model.
  task automatic stp(bit r);
    int e;
    e = (hold || r) ? -1 : pick();
    @(posedge mclk);
    step <= 1'b1;
    ret <= r;
    @(posedge mclk);
    step <= 1'b0;
    ret <= 1'b0;
    @(posedge mclk);
    #1;
    hold = 0;
    if (r) void'(stack.pop_back());
    if (e >= 0) stack.push_back(lvl(e));
    if (e > 0 && e < 5) pend[e] = 0;
    if (e >= 0) last = e;
    chk("irq_take", e >= 0, irq_take);
    if (e >= 0) chk("irq_vector", VEC[e], irq_vector);
    if (e >= 0) chk("irq_line", 16'(e), irq_line);
    chk("clr", {e == 1, e == 2, e == 3, e == 4},
        {clr_ext0, clr_tmr0, clr_ext1, clr_tmr1});
    chk("active_level", 16'(top()), active_level);
  endtask : stp

  // Hang guard.
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    finish_test();
  end

  initial begin
    logic [31:0] d;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(8'hA8, 8'h00);
    rd(8'hE8, 8'hE0);
    rd(8'hB8, 8'h00);
    rd(8'h90, 8'h00);
    $display("test reset values done");
    repeat (6) begin
      d = rnd();
      wr(8'hA8, d[7:0]);
      rd(8'hA8, d[7:0]);
      wr(8'hE8, d[15:8]);
      rd(8'hE8, d[15:8] | 8'hE0);
      wr(8'h90, d[23:16]);
      rd(8'h90, 8'h00);
    end
    $display("test register access done");
    wr(8'hA8, 8'h7F);
    wr(8'hE8, 8'h1F);
    stp(0);
    for (int l = 1; l < 12; l++) flag(l, 1);
    stp(0);
    flag(0, 1);
    stp(0);
    flag(0, 0);
    stp(1);
    $display("test masking done");
    wr(8'hA8, 8'hFF);
    for (int l = 1; l < 12; l++) begin
      stp(0);
      stp(0);
      flag(last, 0);
      stp(1);
    end
    $display("test vectors done");
    wr(8'hB8, 8'h01);
    flag(5, 1);
    stp(0);
    stp(0);
    flag(2, 1);
    stp(0);
    @(posedge mclk);
    ext0_pin_n <= 1'b0;
    ext1_pin_n <= 1'b0;
    repeat (6) @(posedge mclk);
    #1 chk("ext0_req", 16'h0001, ext0_req);
    chk("ext1_req", 16'h0001, ext1_req);
    @(posedge mclk);
    ext0_pin_n <= 1'b1;
    ext1_pin_n <= 1'b1;
    pend[1] = 1;
    repeat (6) @(posedge mclk);
    #1 chk("ext0_req", 16'h0000, ext0_req);
    chk("ext1_req", 16'h0000, ext1_req);
    stp(0);
    stp(1);
    flag(5, 0);
    stp(0);
    stp(1);
    stp(0);
    stp(0);
    stp(1);
    wr(8'hF8, 8'h10);
    flag(9, 1);
    flag(11, 1);
    stp(0);
    stp(0);
    flag(11, 0);
    stp(1);
    stp(0);
    flag(9, 0);
    stp(1);
    $display("test nesting done");
    finish_test();
  end
endmodule : tb_mic_irq_ctrl
